/* File: verilog/page_map_ecc_and_window_decode.sv */
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`default_nettype none
module page_map_ecc_and_window_decode
   import ecc_window_pkg::*;
#(
   parameter int IDX_W = 16
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   output logic [1:0] readStatus,
   output logic readParity,
   input wire logic [3:0] systemNodeId,
   input wire logic [3:0] ioNodeId,
   input wire logic addr30,
   input wire logic [31:0] decAddr,
   output logic windowHit,
   output logic nodespaceHit,
   output logic [31:0] windowBase,
   input wire logic dmaReq,
   input wire logic [IDX_W-1:0] dmaIndex,
   input wire logic dmaWrite,
   output logic dmaDone,
   output logic [31:0] dmaEntry,
   output logic dmaAbort,
   output logic dmaNoAck,
   output logic impliedVectorInterrupt,
   output logic interruptRequest
);
   // =============================================
   // State
   typedef struct packed {
      logic [3:0] sysMeta;
      logic [3:0] sysId;
      logic [3:0] ioMeta;
      logic [3:0] ioId;
      logic modeMeta;
      logic mode30;
      bus_t bus;
      logic wr;
      logic [18:0] off;
      logic [31:0] rdata;
      rsp_t rsp;
      logic parity;
      logic [4:0] summary;
      logic [4:0] mask;
      logic [13:0] window;
      logic winEn;
      logic diagEn;
      logic [11:0] diagChk;
      logic winHit;
      logic nodeHit;
      logic [31:0] winBase;
      logic dDone;
      logic dAbort;
      logic dNoAck;
      logic implied_vector_interrupt;
      logic [31:0] dEntry;
   } state_t;

   state_t s;
   state_t next_s;
   logic [43:0] pageMap [2**IDX_W];
   logic [18:0] pmOff;
   logic pmHit;
   logic [IDX_W-1:0] pmIdx;
   logic [43:0] ahbWord;
   logic [43:0] dmaWord;
   fix_t ahbFix;
   fix_t dmaFix;
   logic [11:0] wrChk;
   logic [13:0] sel;
   logic [31:0] winCalc;
   logic [31:0] nodeCalc;
   logic busyWr;
   logic busyRd;

   // =============================================
   // Page map access and check
   always_comb begin
      pmOff = s.off - OFF_PM_FIRST;
      pmHit = (s.off >= OFF_PM_FIRST) && (pmOff[1:0] == 2'b00)
         && (pmOff[18:IDX_W+2] == '0);
      pmIdx = pmOff[IDX_W+1:2];
      busyWr = (s.bus == BUS_BUSY) && s.wr;
      busyRd = (s.bus == BUS_BUSY) && !s.wr;
      ahbWord = pageMap[pmIdx];
      dmaWord = pageMap[dmaIndex];
      ahbFix = eccFix(ahbWord[31:0], eccSyn(ahbWord[31:0], ahbWord[43:32]));
      dmaFix = eccFix(dmaWord[31:0], eccSyn(dmaWord[31:0], dmaWord[43:32]));
      wrChk = s.diagEn ? s.diagChk : eccSyn(hwdata, 12'h000);
   end

   // whole word plus check written together
   always_ff @(posedge clk_sys) begin
      if (busyWr && pmHit) begin
         pageMap[pmIdx] <= {wrChk, hwdata};
      end
   end

   // =============================================
   // Next state
   always_comb begin
      next_s = s;
      next_s.sysMeta = systemNodeId;
      next_s.sysId = s.sysMeta;
      next_s.ioMeta = ioNodeId;
      next_s.ioId = s.ioMeta;
      next_s.modeMeta = addr30;
      next_s.mode30 = s.modeMeta;
      next_s.dDone = 1'b0;
      next_s.dAbort = 1'b0;
      next_s.dNoAck = 1'b0;
      next_s.implied_vector_interrupt = 1'b0;
      // Bus: one wait state on every transfer
      // locked transfers complete as plain ones
      next_s.bus = BUS_IDLE;
      if (hsel && htrans[1] && hreadyout) begin
         next_s.bus = BUS_BUSY;
         next_s.wr = hwrite;
         next_s.off = haddr[18:0];
      end
      // byte size ignored, full word written
      if (busyWr) begin
         unique case (s.off)
            OFF_SUMMARY: next_s.summary = s.summary & ~hwdata[4:0];
            OFF_MASK: next_s.mask = hwdata[4:0];
            OFF_DIAG: next_s.diagChk = hwdata[11:0];
            OFF_UTILITY: next_s.window = hwdata[13:0];
            OFF_CONTROL: begin
               next_s.winEn = hwdata[CTRL_WIN_EN];
               next_s.diagEn = hwdata[CTRL_DIAG];
            end
            default: ;
         endcase
      end
      if (busyRd) begin
         next_s.rsp = RSP_GOOD;
         next_s.rdata = 32'h0000_0000;
         unique case (s.off)
            OFF_SUMMARY: next_s.rdata = {27'h0, s.summary};
            OFF_MASK: next_s.rdata = {27'h0, s.mask};
            OFF_DIAG: next_s.rdata = {20'h0, s.diagChk};
            OFF_UTILITY: next_s.rdata = {18'h0, s.window};
            OFF_CONTROL: begin
               next_s.rdata[CTRL_WIN_EN] = s.winEn;
               next_s.rdata[CTRL_DIAG] = s.diagEn;
            end
            default: ;
         endcase
         if (pmHit) begin
            next_s.rdata = ahbFix.data;
            if (ahbFix.ce) next_s.rsp = RSP_CORRECTED_READ_DATA;
            if (ahbFix.ue) begin
               next_s.rdata = ahbWord[31:0];
               next_s.rsp = RSP_READ_ERROR;
            end
         end
         next_s.parity = ^next_s.rdata;
      end
      if (dmaReq) begin
         next_s.dDone = 1'b1;
         next_s.dEntry = dmaFix.data;
         next_s.dAbort = dmaFix.ue;
         next_s.dNoAck = dmaFix.ue && !dmaWrite;
         next_s.implied_vector_interrupt = dmaFix.ue && dmaWrite && s.mask[ES_DMA_WUE];
      end
      // log events, set wins over clear
      next_s.summary[ES_RD_CE] = next_s.summary[ES_RD_CE]
         | (busyRd && pmHit && ahbFix.ce);
      next_s.summary[ES_RD_UE] = next_s.summary[ES_RD_UE]
         | (busyRd && pmHit && ahbFix.ue);
      next_s.summary[ES_DMA_CE] = next_s.summary[ES_DMA_CE]
         | (dmaReq && dmaFix.ce);
      next_s.summary[ES_DMA_RUE] = next_s.summary[ES_DMA_RUE]
         | (dmaReq && dmaFix.ue && !dmaWrite);
      next_s.summary[ES_DMA_WUE] = next_s.summary[ES_DMA_WUE]
         | (dmaReq && dmaFix.ue && dmaWrite);
      // relocated window field replaces node ID
      sel = s.winEn ? s.window : {10'h000, s.sysId};
      winCalc = (s.mode30 ? WIN_BASE30 : WIN_BASE32)
         + 32'(32'(sel) * WIN_STEP) + 32'(32'(s.ioId) * IO_STEP);
      nodeCalc = (s.mode30 ? NODE_BASE30 : NODE_BASE32)
         + 32'(32'(s.sysId) * NODE_STEP);
      next_s.winBase = winCalc;
      if (s.mode30) begin
         next_s.winHit = decAddr[A30_MSB:WIN_LSB] == winCalc[A30_MSB:WIN_LSB];
         next_s.nodeHit =
            decAddr[A30_MSB:NODE_LSB] == nodeCalc[A30_MSB:NODE_LSB];
      end else begin
         next_s.winHit = decAddr[31:WIN_LSB] == winCalc[31:WIN_LSB];
         next_s.nodeHit = decAddr[31:NODE_LSB] == nodeCalc[31:NODE_LSB];
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         s <= '0;
         s.bus <= BUS_IDLE;
         s.rsp <= RSP_GOOD;
         s.summary <= ES_RESET;
         s.mask <= MASK_RESET;
         s.window <= UTIL_RESET;
         s.diagChk <= DIAG_RESET;
      end else begin
         s <= next_s;
      end
   end

   // =============================================
   // Outputs
   assign hreadyout = (s.bus == BUS_IDLE);
   assign hresp = 1'b0;
   assign hrdata = s.rdata;
   assign readStatus = s.rsp;
   assign readParity = s.parity;
   assign windowHit = s.winHit;
   assign nodespaceHit = s.nodeHit;
   assign windowBase = s.winBase;
   assign dmaDone = s.dDone;
   assign dmaEntry = s.dEntry;
   assign dmaAbort = s.dAbort;
   assign dmaNoAck = s.dNoAck;
   assign impliedVectorInterrupt = s.implied_vector_interrupt;
   assign interruptRequest = |(s.summary & s.mask);

   // =============================================
   // Assertions
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);

   sequence s_pm_read;
      busyRd && pmHit;
   endsequence
   sequence s_dma_ue;
      dmaReq && dmaFix.ue;
   endsequence

   property p_win_default;
      !reset && !s.winEn && !s.mode30 |=> windowBase == $past(WIN_BASE32
         + 32'(32'(s.sysId) * WIN_STEP) + 32'(32'(s.ioId) * IO_STEP));
   endproperty
   a_win_default: assert property (p_win_default)
      else $error("default window base wrong");

   property p_win_span;
      windowHit && !$past(s.mode30) |->
         windowBase[31:WIN_LSB] == $past(decAddr[31:WIN_LSB]);
   endproperty
   a_win_span: assert property (p_win_span)
      else $error("window hit outside 32 Mbyte span");

   property p_win_reloc;
      s.winEn && !s.mode30 |=> windowBase[31:WIN_LSB] ==
         $past(WIN_BASE32[31:WIN_LSB] + 7'(s.window));
   endproperty
   a_win_reloc: assert property (p_win_reloc)
      else $error("relocated window base wrong");

   property p_node;
      nodespaceHit && !$past(s.mode30) |-> $past(decAddr[31:NODE_LSB])
         == $past(13'((NODE_BASE32 + 32'(s.sysId) * NODE_STEP)
         >> NODE_LSB));
   endproperty
   a_node: assert property (p_node)
      else $error("nodespace hit at wrong base");

   property p_encode;
      busyWr && pmHit && !s.diagEn |=>
         pageMap[$past(pmIdx)] == {eccSyn($past(hwdata), 12'h000),
         $past(hwdata)};
   endproperty
   a_encode: assert property (p_encode)
      else $error("page map write code wrong");

   property p_crd;
      s_pm_read ##0 ahbFix.ce |=> readStatus == RSP_CORRECTED_READ_DATA
         && hrdata == $past(ahbFix.data) && s.summary[ES_RD_CE];
   endproperty
   a_crd: assert property (p_crd)
      else $error("corrected read not reported");

   property p_rer;
      s_pm_read ##0 ahbFix.ue |=> readStatus == RSP_READ_ERROR
         && hrdata == $past(ahbWord[31:0]) && readParity == ^hrdata
         && s.summary[ES_RD_UE];
   endproperty
   a_rer: assert property (p_rer)
      else $error("uncorrectable read not reported");

   property p_dma_ce;
      dmaReq && dmaFix.ce |=> dmaDone && !dmaAbort
         && dmaEntry == $past(dmaFix.data) && s.summary[ES_DMA_CE];
   endproperty
   a_dma_ce: assert property (p_dma_ce)
      else $error("corrected translation wrong");

   property p_dma_rd_ue;
      s_dma_ue ##0 !dmaWrite |=> dmaAbort && dmaNoAck
         && !impliedVectorInterrupt && s.summary[ES_DMA_RUE];
   endproperty
   a_dma_rd_ue: assert property (p_dma_rd_ue)
      else $error("read translation error not aborted");

   property p_dma_wr_ue;
      s_dma_ue ##0 dmaWrite |=> dmaAbort && !dmaNoAck
         && impliedVectorInterrupt == $past(s.mask[ES_DMA_WUE]);
   endproperty
   a_dma_wr_ue: assert property (p_dma_wr_ue)
      else $error("write translation error not aborted");

   property p_intr;
      s_dma_ue ##0 s.mask[ES_DMA_CE +: 3] == 3'h7 |=> interruptRequest;
   endproperty
   a_intr: assert property (p_intr)
      else $error("enabled error raised no interrupt");

   property p_fullword;
      busyWr && s.off == OFF_UTILITY |=> s.window == $past(hwdata[13:0]);
   endproperty
   a_fullword: assert property (p_fullword)
      else $error("register write not taken as full word");
endmodule
`default_nettype wire

/* File: verilog/ecc_window_pkg.sv */
`default_nettype none
package ecc_window_pkg;
   // =============================================
   // Address decode
   localparam logic [31:0] WIN_BASE32 = 32'hE000_0000;
   localparam logic [31:0] WIN_BASE30 = 32'h2000_0000;
   localparam logic [31:0] WIN_STEP = 32'h0200_0000;
   localparam logic [31:0] IO_STEP = 32'h0000_2000;
   localparam logic [31:0] NODE_BASE32 = 32'hE180_0000;
   localparam logic [31:0] NODE_BASE30 = 32'h2180_0000;
   localparam logic [31:0] NODE_STEP = 32'h0008_0000;
   localparam int WIN_LSB = 25;
   localparam int NODE_LSB = 19;
   localparam int A30_MSB = 29;
   // =============================================
   // Register offsets and fields
   localparam logic [18:0] OFF_SUMMARY = 19'h0_0010;
   localparam logic [18:0] OFF_MASK = 19'h0_0014;
   localparam logic [18:0] OFF_DIAG = 19'h0_001C;
   localparam logic [18:0] OFF_UTILITY = 19'h0_0020;
   localparam logic [18:0] OFF_CONTROL = 19'h0_0024;
   localparam logic [18:0] OFF_PM_FIRST = 19'h0_0200;
   localparam int CTRL_WIN_EN = 5;
   localparam int CTRL_DIAG = 0;
   localparam int ES_RD_CE = 0;
   localparam int ES_RD_UE = 1;
   localparam int ES_DMA_CE = 2;
   localparam int ES_DMA_RUE = 3;
   localparam int ES_DMA_WUE = 4;
   localparam logic [4:0] ES_RESET = 5'h00;
   localparam logic [4:0] MASK_RESET = 5'h00;
   localparam logic [13:0] UTIL_RESET = 14'h0000;
   localparam logic [11:0] DIAG_RESET = 12'h000;
   // =============================================
   // Types
   typedef enum logic [1:0] {RSP_GOOD, RSP_CORRECTED_READ_DATA,
      RSP_READ_ERROR} rsp_t;
   typedef enum logic {BUS_IDLE, BUS_BUSY} bus_t;
   typedef struct packed {
      logic ue;
      logic ce;
      logic [31:0] data;
   } fix_t;
   // =============================================
   // Symbol code over GF(16), x^4 + x + 1
   function automatic logic [3:0] gfMul(input logic [3:0] a,
         input logic [3:0] b);
      logic [3:0] p;
      logic [3:0] x;
      p = 4'h0;
      x = a;
      for (int i = 0; i < 4; i++) begin
         if (b[i]) p = p ^ x;
         x = {x[2:0], 1'b0} ^ (x[3] ? 4'h3 : 4'h0);
      end
      return p;
   endfunction
   // Data nibble i has column (1, a^i, a^2i); check nibbles are units
   function automatic logic [11:0] eccSyn(input logic [31:0] d,
         input logic [11:0] c);
      logic [3:0] s0, s1, s2, p1, p2;
      s0 = c[3:0];
      s1 = c[7:4];
      s2 = c[11:8];
      p1 = 4'h1;
      p2 = 4'h1;
      for (int i = 0; i < 8; i++) begin
         s0 = s0 ^ d[4*i +: 4];
         s1 = s1 ^ gfMul(p1, d[4*i +: 4]);
         s2 = s2 ^ gfMul(p2, d[4*i +: 4]);
         p1 = gfMul(p1, 4'h2);
         p2 = gfMul(p2, 4'h4);
      end
      return {s2, s1, s0};
   endfunction
   function automatic fix_t eccFix(input logic [31:0] d,
         input logic [11:0] s);
      fix_t f;
      logic [3:0] p1, p2;
      logic hit;
      f.data = d;
      f.ce = 1'b0;
      f.ue = 1'b0;
      p1 = 4'h1;
      p2 = 4'h1;
      hit = $onehot({|s[3:0], |s[7:4], |s[11:8]});
      for (int i = 0; i < 8; i++) begin
         if (s[3:0] != 4'h0 && s[7:4] == gfMul(p1, s[3:0])
               && s[11:8] == gfMul(p2, s[3:0])) begin
            f.data[4*i +: 4] = d[4*i +: 4] ^ s[3:0];
            hit = 1'b1;
         end
         p1 = gfMul(p1, 4'h2);
         p2 = gfMul(p2, 4'h4);
      end
      f.ce = hit;
      f.ue = (s != 12'h000) && !hit;
      return f;
   endfunction
endpackage
`default_nettype wire

/* File: tb/bus_commander_model.sv */
`default_nettype none
module bus_commander_model (
   input wire logic clk_sys,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic [1:0] readStatus,
   input wire logic readParity,
   input wire logic dmaDone,
   input wire logic [31:0] dmaEntry,
   input wire logic dmaAbort,
   input wire logic dmaNoAck,
   input wire logic impliedVectorInterrupt,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   output logic dmaReq,
   output logic [3:0] dmaIndex,
   output logic dmaWrite,
   output logic hung
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      dmaReq = 1'b0;
      dmaIndex = 4'h0;
      dmaWrite = 1'b0;
      hung = 1'b0;
   end
   // ==========================================
   // Bus phases
   task automatic waitReady();
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hreadyout !== 1'b1 && n < 64);
      if (hreadyout !== 1'b1) hung <= 1'b1;
   endtask
   task automatic ahbXfer(input logic wr, input logic [18:0] off,
         input logic [31:0] d, input logic [2:0] sz,
         output logic [31:0] rd, output logic [1:0] st,
         output logic par);
      hsel <= 1'b1;
      haddr <= {13'h0, off};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= sz;
      waitReady();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      waitReady();
      rd = hrdata;
      st = readStatus;
      par = readParity;
      hwdata <= ~d;
   endtask
   // ==========================================
   // Two back-to-back translations
   task automatic dmaPair(input logic [7:0] idx, input logic [1:0] wr,
         output logic [1:0][35:0] r);
      dmaReq <= 1'b1;
      dmaIndex <= idx[3:0];
      dmaWrite <= wr[0];
      @(posedge clk_sys);
      dmaIndex <= idx[7:4];
      dmaWrite <= wr[1];
      @(posedge clk_sys);
      dmaReq <= 1'b0;
      dmaIndex <= ~idx[7:4];
      r[0] = {dmaNoAck, impliedVectorInterrupt, dmaAbort, dmaDone,
         dmaEntry};
      @(posedge clk_sys);
      r[1] = {dmaNoAck, impliedVectorInterrupt, dmaAbort, dmaDone,
         dmaEntry};
   endtask
endmodule
`default_nettype wire

/* File: tb/test_page_map_ecc_and_window_decode.sv */
`default_nettype none
`define CHK(nm, ex, got) \
   begin \
      tests_run++; \
      if ((got) !== (ex)) begin \
         num_errors++; \
         $display("mismatch %s expected %h seen %h", nm, ex, got); \
      end \
   end
module test_page_map_ecc_and_window_decode
   import ecc_window_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, reset, hsel, hwrite, hreadyout, hresp, readParity;
   logic [31:0] haddr, hwdata, hrdata, decAddr, windowBase, dmaEntry;
   logic [1:0] htrans, readStatus;
   logic [2:0] hsize;
   logic [3:0] systemNodeId, ioNodeId, dmaIndex;
   logic addr30, windowHit, nodespaceHit, dmaReq, dmaWrite, dmaDone;
   logic dmaAbort, dmaNoAck, impliedVectorInterrupt, interruptRequest;
   logic hung, par;
   logic [31:0] rd;
   logic [1:0] st;
   logic [1:0][35:0] dr;
   int num_errors, tests_run;
   typedef struct packed {
      logic [3:0] sn, io;
      logic a30, en;
      logic [13:0] util;
      logic [31:0] addr, base;
      logic [1:0] hit;
   } dec_row_t;
   typedef struct packed {
      logic [3:0] idx;
      logic diag;
      logic [11:0] chk;
      logic [31:0] data, exp;
      rsp_t rsp;
   } ecc_row_t;
   dec_row_t decRows [8] = '{
      '{4'h3, 4'h5, 1'b0, 1'b0, 14'h0, 32'hE600_A000, 32'hE600_A000, 2'h2},
      '{4'h3, 4'h5, 1'b0, 1'b0, 14'h0, 32'hE198_0024, 32'hE600_A000, 2'h1},
      '{4'h2, 4'h1, 1'b1, 1'b0, 14'h0, 32'h2500_0000, 32'h2400_2000, 2'h2},
      '{4'h2, 4'h1, 1'b1, 1'b0, 14'h0, 32'h2190_0008, 32'h2400_2000, 2'h1},
      '{4'h2, 4'h1, 1'b0, 1'b1, 14'h5, 32'hEA00_0000, 32'hEA00_2000, 2'h2},
      '{4'h2, 4'h1, 1'b0, 1'b1, 14'h5, 32'hE400_2000, 32'hEA00_2000, 2'h0},
      '{4'h2, 4'h1, 1'b1, 1'b1, 14'h5, 32'h2A00_0000, 32'h2A00_2000, 2'h2},
      '{4'h2, 4'h7, 1'b0, 1'b1, 14'hF, 32'hE190_0000, 32'hFE00_E000, 2'h1}};
   ecc_row_t eccRows [6] = '{
      '{4'h1, 1'b0, 12'h0, 32'h1234_5678, 32'h1234_5678, RSP_GOOD},
      '{4'hF, 1'b0, 12'h0, 32'hA5A5_5A5A, 32'hA5A5_5A5A, RSP_GOOD},
      '{4'h2, 1'b1, 12'h0, 32'h5, 32'h0, RSP_CORRECTED_READ_DATA},
      '{4'h3, 1'b1, 12'h0, 32'hF000_0000, 32'h0, RSP_CORRECTED_READ_DATA},
      '{4'h4, 1'b1, 12'h00A, 32'h0, 32'h0, RSP_CORRECTED_READ_DATA},
      '{4'h5, 1'b1, 12'h0, 32'h13, 32'h13, RSP_READ_ERROR}};
   logic [18:0] regOff [6] = '{OFF_SUMMARY, OFF_MASK, OFF_DIAG,
      OFF_UTILITY, OFF_CONTROL, 19'h0_0030};
   page_map_ecc_and_window_decode #(.IDX_W(4))
         u_page_map_ecc_and_window_decode (.clk_sys, .reset, .hsel,
      .haddr, .htrans, .hwrite, .hsize, .hwdata, .hreadyout, .hrdata,
      .hresp, .readStatus, .readParity, .systemNodeId, .ioNodeId, .addr30,
      .decAddr, .windowHit, .nodespaceHit, .windowBase, .dmaReq, .dmaIndex,
      .dmaWrite, .dmaDone, .dmaEntry, .dmaAbort, .dmaNoAck,
      .impliedVectorInterrupt, .interruptRequest);
   bus_commander_model u_bus_commander_model (.clk_sys, .hreadyout,
      .hrdata, .readStatus, .readParity, .dmaDone, .dmaEntry, .dmaAbort,
      .dmaNoAck, .impliedVectorInterrupt, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .dmaReq, .dmaIndex, .dmaWrite, .hung);
   task automatic wr(input logic [18:0] off, input logic [31:0] d);
      u_bus_commander_model.ahbXfer(1'b1, off, d, 3'h2, rd, st, par);
   endtask
   task automatic rdReg(input logic [18:0] off);
      u_bus_commander_model.ahbXfer(1'b0, off, 32'h0, 3'h2, rd, st, par);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge hung) begin
      num_errors++;
      final_report();
   end
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      num_errors = 0;
      tests_run = 0;
      reset = 1'b1;
      systemNodeId = 4'h3;
      ioNodeId = 4'h5;
      addr30 = 1'b0;
      decAddr = 32'h0;
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (4) @(posedge clk_sys);
      // ==========================================
      // Register defaults and byte-sized write
      foreach (regOff[i]) begin
         rdReg(regOff[i]);
         `CHK("reset value", 32'h0, rd)
      end
      `CHK("hresp", 1'b0, hresp)
      u_bus_commander_model.ahbXfer(1'b1, OFF_MASK, 32'h1F, 3'h0, rd, st,
         par);
      rdReg(OFF_MASK);
      `CHK("mask", 32'h1F, rd)
      wr(OFF_MASK, 32'h0);
      // ==========================================
      // Window and nodespace decode
      foreach (decRows[i]) begin
         wr(OFF_UTILITY, {18'h0, decRows[i].util});
         wr(OFF_CONTROL, {26'h0, decRows[i].en, 5'h0});
         systemNodeId <= decRows[i].sn;
         ioNodeId <= decRows[i].io;
         addr30 <= decRows[i].a30;
         decAddr <= decRows[i].addr;
         repeat (5) @(posedge clk_sys);
         `CHK("windowBase", decRows[i].base, windowBase)
         `CHK("windowHit", decRows[i].hit[1], windowHit)
         `CHK("nodespaceHit", decRows[i].hit[0], nodespaceHit)
      end
      // ==========================================
      // Page map code, correction and detection
      foreach (eccRows[i]) begin
         wr(OFF_DIAG, {20'h0, eccRows[i].chk});
         wr(OFF_CONTROL, {31'h0, eccRows[i].diag});
         wr(OFF_PM_FIRST + {13'h0, eccRows[i].idx, 2'b00}, eccRows[i].data);
         rdReg(OFF_PM_FIRST + {13'h0, eccRows[i].idx, 2'b00});
         `CHK("pm data", eccRows[i].exp, rd)
         `CHK("status", eccRows[i].rsp, st)
         `CHK("parity", ^eccRows[i].exp, par)
      end
      rdReg(OFF_SUMMARY);
      `CHK("summary", 32'h3, rd)
      `CHK("irq masked", 1'b0, interruptRequest)
      wr(OFF_MASK, 32'h1F);
      `CHK("irq", 1'b1, interruptRequest)
      wr(OFF_SUMMARY, 32'h3);
      `CHK("irq cleared", 1'b0, interruptRequest)
      // ==========================================
      // Translations back to back
      u_bus_commander_model.dmaPair(8'h52, 2'b00, dr);
      `CHK("dma ce", 36'h1_0000_0000, dr[0])
      `CHK("dma read ue", 4'hB, dr[1][35:32])
      u_bus_commander_model.dmaPair(8'h15, 2'b11, dr);
      `CHK("dma write ue", 4'h7, dr[0][35:32])
      `CHK("dma good", 36'h1_1234_5678, dr[1])
      rdReg(OFF_SUMMARY);
      `CHK("summary dma", 32'h1C, rd)
      `CHK("irq dma", 1'b1, interruptRequest)
      wr(OFF_MASK, 32'h0F);
      u_bus_commander_model.dmaPair(8'h55, 2'b11, dr);
      `CHK("iv masked", 4'h3, dr[1][35:32])
      // ==========================================
      // Second reset in mid-run
      reset <= 1'b1;
      repeat (3) @(posedge clk_sys);
      `CHK("irq in reset", 1'b0, interruptRequest)
      `CHK("ready in reset", 1'b1, hreadyout)
      reset <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rdReg(OFF_SUMMARY);
      `CHK("summary after reset", 32'h0, rd)
      rdReg(OFF_CONTROL);
      `CHK("control after reset", 32'h0, rd)
      `CHK("default base", 32'hE400_E000, windowBase)
      final_report();
   end
endmodule
`default_nettype wire
